// ===== include/ilc_pkg.sv
// Shared constants and types for the input link checker and clock monitor
package ilc_pkg;
    // Register indices on the serial port
    localparam logic [4:0] REG_TEST_CTRL = 5'h01;
    localparam logic [4:0] REG_ALARM_FLAGS = 5'h07;
    localparam logic [4:0] REG_LANE_ERR = 5'h08;
    localparam logic [4:0] REG_KEY_BASE = 5'h09;
    localparam logic [4:0] REG_KEY_LAST = 5'h10;
    localparam logic [4:0] REG_MON_CTRL = 5'h11;
    localparam logic [4:0] REG_SYNC_SEL = 5'h13;
    localparam logic [4:0] REG_MON_STAT = 5'h1F;
    // Field positions
    localparam int TEST_EN_BIT = 0;
    localparam int INTERP_LSB = 1;
    localparam int PAT_ERR_BIT = 3;
    localparam int ARM_MUTE_BIT = 0;
    localparam int ARM_LOSS_BIT = 1;
    localparam int MASK_MUTE_BIT = 3;
    localparam int MASK_LOSS_BIT = 4;
    localparam int STAT_MUTE_BIT = 6;
    localparam int STAT_LOSS_BIT = 7;
    localparam int DUAL_SYNC_BIT = 0;
    localparam int SPI_RW_BIT = 7;
    // Reset values
    localparam logic [7:0] KEY0_RESET = 8'h7A;
    localparam logic [7:0] KEYN_RESET = 8'h00;
    localparam logic [7:0] TEST_CTRL_RESET = 8'h00;
    localparam logic [7:0] MON_CTRL_RESET = 8'h00;
    localparam logic [7:0] SYNC_SEL_RESET = 8'h00;
    localparam logic [2:0] READ_PTR_RESET = 3'h4;
    // Monitor and data path
    localparam logic [2:0] LOSS_COUNT = 3'h4;
    localparam logic [15:0] MIDSCALE = 16'h8000;
    // Read clock divide limits per interpolation code, then the last serial bit index
    localparam logic [1:0] DIV_LIM_1X = 2'h0;
    localparam logic [1:0] DIV_LIM_2X = 2'h1;
    localparam logic [1:0] DIV_LIM_4X = 2'h3;
    localparam logic [3:0] SPI_LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_CMD = 3'b010,
        SP_DATA = 3'b100
    } ilc_spi_st_t;

    typedef enum logic [2:0] {
        CK_OFF = 3'b001,
        CK_WAIT = 3'b010,
        CK_RUN = 3'b100
    } ilc_chk_st_t;
endpackage

// ===== include/ilc_reg_if.sv
// Register access carrier between serial port and block core
`timescale 1ns/100ps
`default_nettype none
interface ilc_reg_if;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output wr, output addr, output wdata, input rdata);
    modport slave (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== rtl/ilc_key_mem.sv
// Eight-word pattern key store with two registered read ports
`timescale 1ns/100ps
`default_nettype none
module ilc_key_mem
    import ilc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [2:0] rd_addr_a_i,
    input wire logic [2:0] rd_addr_b_i,
    output logic [7:0] rd_a_o,
    output logic [7:0] rd_b_o
);
    typedef struct packed {
        logic [7:0][7:0] words;
        logic [7:0] rd_a;
        logic [7:0] rd_b;
    } ilc_mem_state_t;

    ilc_mem_state_t mem_reg, mem_next;

    // Write port and both registered reads
    always_comb begin
        mem_next = mem_reg;
        if (wr_en_i) begin
            mem_next.words[wr_addr_i] = wr_data_i;
        end
        mem_next.rd_a = mem_reg.words[rd_addr_a_i];
        mem_next.rd_b = mem_reg.words[rd_addr_b_i];
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mem_reg <= '0;
            mem_reg.words <= {{7{KEYN_RESET}}, KEY0_RESET};
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rd_a_o = mem_reg.rd_a;
    assign rd_b_o = mem_reg.rd_b;
endmodule
`default_nettype wire

// ===== rtl/ilc_serial_port.sv
// Three-wire serial register port, sampled in the system clock
`timescale 1ns/100ps
`default_nettype none
module ilc_serial_port
    import ilc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic serial_clk_i,
    input wire logic serial_enable_n_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_n_o,
    ilc_reg_if.master bus
);
    typedef struct packed {
        ilc_spi_st_t st;
        logic sclk_q;
        logic [3:0] bitcnt;
        logic [7:0] cmd;
        logic [7:0] dat;
        logic wr;
        logic sdo;
        logic oe_n;
    } ilc_spi_state_t;

    ilc_spi_state_t s_reg, s_next;
    logic sclk_rise;
    logic sclk_fall;
    logic is_read;

    assign sclk_rise = serial_clk_i & ~s_reg.sclk_q;
    assign sclk_fall = ~serial_clk_i & s_reg.sclk_q;
    assign is_read = s_reg.cmd[SPI_RW_BIT];

    // Command byte then data byte, MSB first, shifted in on rising edges, read data shifted out on falling edges
    always_comb begin
        s_next = s_reg;
        s_next.sclk_q = serial_clk_i;
        s_next.wr = 1'b0;
        if (serial_enable_n_i) begin
            s_next.st = SP_IDLE;
            s_next.bitcnt = '0;
            s_next.oe_n = 1'b1;
        end else begin
            unique case (s_reg.st)
                SP_IDLE: begin
                    s_next.st = SP_CMD;
                end
                SP_CMD: begin
                    if (sclk_rise) begin
                        s_next.cmd = {s_reg.cmd[6:0], serial_data_i};
                        s_next.bitcnt = s_reg.bitcnt + 4'h1;
                        if (s_reg.bitcnt == SPI_LAST_BIT) begin
                            s_next.st = SP_DATA;
                            s_next.bitcnt = '0;
                        end
                    end
                end
                SP_DATA: begin
                    if (sclk_rise && !is_read) begin
                        s_next.dat = {s_reg.dat[6:0], serial_data_i};
                        s_next.bitcnt = s_reg.bitcnt + 4'h1;
                        s_next.wr = (s_reg.bitcnt == SPI_LAST_BIT);
                    end
                    // Read data is loaded at the first falling edge
                    if (sclk_fall && is_read) begin
                        s_next.oe_n = 1'b0;
                        s_next.bitcnt = s_reg.bitcnt + 4'h1;
                        if (s_reg.bitcnt == 4'h0) begin
                            s_next.sdo = bus.rdata[7];
                            s_next.dat = {bus.rdata[6:0], 1'b0};
                        end else begin
                            s_next.sdo = s_reg.dat[7];
                            s_next.dat = {s_reg.dat[6:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_reg <= '0;
            s_reg.st <= SP_IDLE;
            s_reg.oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.wr = s_reg.wr;
    assign bus.addr = s_reg.cmd[4:0];
    assign bus.wdata = s_reg.dat;
    assign serial_data_o = s_reg.sdo;
    assign serial_data_oe_n_o = s_reg.oe_n;
endmodule
`default_nettype wire

// ===== rtl/ilc_link_check.sv
// Input link pattern checker, data clock monitor and read sync select
//
// What this block does
// - Pattern check enable holds analog outputs off regardless of enable pin.
// - Eight writable key bytes in consecutive registers are the compare key.
// - Each mismatching data lane sets its own error field bit.
// - Any mismatch sets the pattern error flag, alarm register bit 3.
// - First key word resets to 0x7A.
// - Writing zero clears error field and flag; persisting errors set again.
// - Monitor counter clears on data clock rise, counts on read clock.
// - Count of four without data clock sets loss and mute latches.
// - Arm bit one enables its latch; zero holds it cleared.
// - Status register shows loss latch at bit 7, mute at bit 6.
// - Mute latch set replaces output samples with mid-scale code.
// - Both alarms drive alarm pin unless masked by bits 4 and 3.
// - Output strobe sampled on conversion clock resets read pointer.
// - Single sync mode resamples frame pointer reset on read clock.
// - Read clock is conversion clock divided by interpolation factor.
// - Frame marker is taken only on data clock rising edges.
`timescale 1ns/100ps
`default_nettype none
module ilc_link_check
    import ilc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic input_data_clock_i,
    input wire logic frame_marker_i,
    input wire logic [7:0] link_data_i,
    input wire logic conversion_clock_i,
    input wire logic output_strobe_sync_i,
    input wire logic output_enable_pin_i,
    input wire logic [15:0] sample_i,
    input wire logic serial_clk_i,
    input wire logic serial_enable_n_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_n_o,
    output logic alarm_output_pin_o,
    output logic analog_active_o,
    output logic [15:0] sample_o,
    output logic [2:0] read_ptr_o,
    output logic read_ptr_reset_o
);
    typedef struct packed {
        logic dclk_q;
        logic frame_q;
        logic cclk_q;
        logic output_strobe_sync_s;
        logic [7:0] test_ctrl;
        logic [7:0] sync_sel;
        logic [7:0] mon_ctrl;
        logic [7:0] lane_err;
        logic pat_err;
        ilc_chk_st_t ck_st;
        logic [2:0] key_idx;
        logic cmp_valid;
        logic [7:0] cmp_data;
        logic [1:0] div_cnt;
        logic [2:0] mon_cnt;
        logic loss_latch;
        logic mute_latch;
        logic [2:0] rd_ptr;
        logic rd_pend;
        logic rd_rst;
        logic alarm_pin;
        logic analog_act;
        logic [15:0] sample;
        logic [7:0] rdata;
    } ilc_core_state_t;

    ilc_core_state_t c_reg, c_next;
    ilc_reg_if reg_bus ();

    // Every assertion below runs on the system clock
    default clocking ck_a @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    logic [7:0] key_rd_sw;
    logic [7:0] key_rd_chk;
    logic [2:0] chk_addr;
    logic [4:0] key_off;
    logic key_wr;
    logic dclk_rise;
    logic dclk_edge;
    logic frame_rise;
    logic cclk_rise;
    logic output_strobe_sync_rise;
    logic rd_tick;
    logic loss_pulse;
    logic test_en;
    logic dual_sync;
    logic [1:0] div_lim;
    logic [7:0] mism;

    ilc_serial_port u_port (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .serial_clk_i(serial_clk_i),
        .serial_enable_n_i(serial_enable_n_i),
        .serial_data_i(serial_data_i),
        .serial_data_o(serial_data_o),
        .serial_data_oe_n_o(serial_data_oe_n_o),
        .bus(reg_bus.master)
    );

    // Key words sit at consecutive indices
    assign key_off = reg_bus.addr - REG_KEY_BASE;
    assign key_wr = reg_bus.wr && reg_bus.addr >= REG_KEY_BASE
        && reg_bus.addr <= REG_KEY_LAST;

    ilc_key_mem u_key (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .wr_en_i(key_wr),
        .wr_addr_i(key_off[2:0]),
        .wr_data_i(reg_bus.wdata),
        .rd_addr_a_i(key_off[2:0]),
        .rd_addr_b_i(chk_addr),
        .rd_a_o(key_rd_sw),
        .rd_b_o(key_rd_chk)
    );

    // Edge detection on pins already synchronous to the system clock
    assign dclk_rise = input_data_clock_i & ~c_reg.dclk_q;
    assign dclk_edge = input_data_clock_i ^ c_reg.dclk_q;
    // frame only seen at data clock rise
    assign frame_rise = dclk_rise & frame_marker_i & ~c_reg.frame_q;
    assign cclk_rise = conversion_clock_i & ~c_reg.cclk_q;
    assign output_strobe_sync_rise = cclk_rise & output_strobe_sync_i & ~c_reg.output_strobe_sync_s;
    assign test_en = c_reg.test_ctrl[TEST_EN_BIT];
    assign dual_sync = c_reg.sync_sel[DUAL_SYNC_BIT];

    always_comb begin
        unique case (c_reg.test_ctrl[INTERP_LSB +: 2])
            2'h0: div_lim = DIV_LIM_1X;
            2'h1: div_lim = DIV_LIM_2X;
            2'h2: div_lim = DIV_LIM_4X;
            2'h3: div_lim = DIV_LIM_4X;
        endcase
    end
    assign rd_tick = cclk_rise && c_reg.div_cnt == div_lim;

    // one pulse as the count reaches four
    assign loss_pulse = rd_tick && !dclk_rise
        && c_reg.mon_cnt == LOSS_COUNT - 3'h1;

    // lane compare against the key word read last cycle
    assign mism = c_reg.cmp_valid ? (c_reg.cmp_data ^ key_rd_chk) : 8'h00;

    // Main next-state logic
    always_comb begin
        c_next = c_reg;
        c_next.dclk_q = input_data_clock_i;
        c_next.cclk_q = conversion_clock_i;
        c_next.cmp_valid = 1'b0;
        c_next.rd_rst = 1'b0;
        chk_addr = c_reg.key_idx;
        if (dclk_rise) begin
            c_next.frame_q = frame_marker_i;
        end
        if (cclk_rise) begin
            c_next.output_strobe_sync_s = output_strobe_sync_i;
        end

        // Plain control registers
        if (reg_bus.wr) begin
            unique case (reg_bus.addr)
                REG_TEST_CTRL: c_next.test_ctrl = reg_bus.wdata;
                REG_SYNC_SEL: c_next.sync_sel = reg_bus.wdata;
                REG_MON_CTRL: c_next.mon_ctrl = reg_bus.wdata;
                default: ;
            endcase
        end

        // sequence alignment; a frame rise realigns to word 0
        unique case (c_reg.ck_st)
            CK_OFF: begin
                if (test_en) begin
                    c_next.ck_st = CK_WAIT;
                end
            end
            CK_WAIT: begin
                if (!test_en) begin
                    c_next.ck_st = CK_OFF;
                end else if (frame_rise) begin
                    chk_addr = 3'h0;
                    c_next.cmp_valid = 1'b1;
                    c_next.cmp_data = link_data_i;
                    c_next.key_idx = 3'h1;
                    c_next.ck_st = CK_RUN;
                end
            end
            CK_RUN: begin
                if (!test_en) begin
                    c_next.ck_st = CK_OFF;
                end else if (dclk_edge) begin
                    chk_addr = frame_rise ? 3'h0 : c_reg.key_idx;
                    c_next.cmp_valid = 1'b1;
                    c_next.cmp_data = link_data_i;
                    c_next.key_idx = chk_addr + 3'h1;
                end
            end
        endcase

        // write clears, a fresh mismatch wins over the clear
        if (reg_bus.wr && reg_bus.addr == REG_LANE_ERR) begin
            c_next.lane_err = reg_bus.wdata;
        end
        if (reg_bus.wr && reg_bus.addr == REG_ALARM_FLAGS) begin
            c_next.pat_err = reg_bus.wdata[PAT_ERR_BIT];
        end
        c_next.lane_err = c_next.lane_err | mism;
        c_next.pat_err = c_next.pat_err | (|mism);

        if (cclk_rise) begin
            c_next.div_cnt = rd_tick ? 2'h0 : c_reg.div_cnt + 2'h1;
        end

        if (dclk_rise) begin
            c_next.mon_cnt = 3'h0;
        end else if (rd_tick && c_reg.mon_cnt != LOSS_COUNT) begin
            c_next.mon_cnt = c_reg.mon_cnt + 3'h1;
        end

        // latches held clear while their arm bit is zero
        c_next.loss_latch = c_reg.mon_ctrl[ARM_LOSS_BIT]
            & (c_reg.loss_latch | loss_pulse);
        c_next.mute_latch = c_reg.mon_ctrl[ARM_MUTE_BIT]
            & (c_reg.mute_latch | loss_pulse);

        c_next.sample = c_reg.mute_latch ? MIDSCALE : sample_i;
        c_next.analog_act = output_enable_pin_i & ~test_en;
        // unmasked latches drive the alarm pin
        c_next.alarm_pin =
            (c_reg.loss_latch & ~c_reg.mon_ctrl[MASK_LOSS_BIT])
            | (c_reg.mute_latch & ~c_reg.mon_ctrl[MASK_MUTE_BIT]);

        // frame reset waits for the next read clock tick
        c_next.rd_pend = frame_rise | (c_reg.rd_pend & ~rd_tick);
        // strobe drives read reset in dual mode
        c_next.rd_rst = dual_sync ? output_strobe_sync_rise : (rd_tick & c_reg.rd_pend);
        if (c_next.rd_rst) begin
            c_next.rd_ptr = READ_PTR_RESET;
        end else if (rd_tick) begin
            c_next.rd_ptr = c_reg.rd_ptr + 3'h1;
        end

        // Read mux; unmapped indices read zero, control registers return every written bit
        unique case (reg_bus.addr)
            REG_TEST_CTRL: c_next.rdata = c_reg.test_ctrl;
            REG_SYNC_SEL: c_next.rdata = c_reg.sync_sel;
            REG_MON_CTRL: c_next.rdata = c_reg.mon_ctrl;
            REG_LANE_ERR: c_next.rdata = c_reg.lane_err;
            REG_ALARM_FLAGS: c_next.rdata = 8'(c_reg.pat_err) << PAT_ERR_BIT;
            REG_MON_STAT: c_next.rdata =
                (8'(c_reg.loss_latch) << STAT_LOSS_BIT)
                | (8'(c_reg.mute_latch) << STAT_MUTE_BIT);
            default: c_next.rdata =
                key_wr || (key_off <= REG_KEY_LAST - REG_KEY_BASE)
                ? key_rd_sw : 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            c_reg <= '0;
            c_reg.ck_st <= CK_OFF;
            c_reg.test_ctrl <= TEST_CTRL_RESET;
            c_reg.sync_sel <= SYNC_SEL_RESET;
            c_reg.mon_ctrl <= MON_CTRL_RESET;
            c_reg.rd_ptr <= READ_PTR_RESET;
        end else begin
            c_reg <= c_next;
        end
    end

    assign reg_bus.rdata = c_reg.rdata;
    assign alarm_output_pin_o = c_reg.alarm_pin;
    assign analog_active_o = c_reg.analog_act;
    assign sample_o = c_reg.sample;
    assign read_ptr_o = c_reg.rd_ptr;
    assign read_ptr_reset_o = c_reg.rd_rst;

    AST_TEST_SILENCES: assert property (
        test_en |=> !analog_active_o) else $error("output active in test");
    AST_LANE_BITS: assert property (
        mism != 8'h00 |=> (c_reg.lane_err & $past(mism)) == $past(mism))
        else $error("lane error bit missing");
    AST_PAT_FLAG: assert property (
        mism != 8'h00 |=> c_reg.pat_err) else $error("pattern flag not set");
    AST_CLEAR_LANES: assert property (
        reg_bus.wr && reg_bus.addr == REG_LANE_ERR && reg_bus.wdata == 8'h00
        && mism == 8'h00 |=> c_reg.lane_err == 8'h00)
        else $error("lane errors not cleared");
    AST_MON_CLEAR: assert property (
        dclk_rise |=> c_reg.mon_cnt == 3'h0) else $error("counter not reset");
    AST_LOSS_SETS: assert property (
        loss_pulse && c_reg.mon_ctrl[ARM_LOSS_BIT]
        && c_reg.mon_ctrl[ARM_MUTE_BIT]
        |=> c_reg.loss_latch && c_reg.mute_latch)
        else $error("loss did not set both latches");
    AST_ARM_HOLDS: assert property (
        !c_reg.mon_ctrl[ARM_LOSS_BIT] [*2] |-> !c_reg.loss_latch)
        else $error("disarmed latch set");
    AST_MIDSCALE: assert property (
        c_reg.mute_latch |=> sample_o == MIDSCALE)
        else $error("muted output not mid-scale");
    AST_ALARM_PIN: assert property (
        c_reg.loss_latch && !c_reg.mon_ctrl[MASK_LOSS_BIT]
        |=> alarm_output_pin_o) else $error("alarm pin missed loss");
    AST_STROBE_SYNC: assert property (
        dual_sync && output_strobe_sync_rise |=> read_ptr_reset_o
        && read_ptr_o == READ_PTR_RESET) else $error("strobe reset lost");

    COV_LOSS: cover property (loss_pulse);
    COV_PAT_ERR: cover property (mism != 8'h00);
    COV_SINGLE_SYNC: cover property (!dual_sync && read_ptr_reset_o);
    COV_KEY_WRITE: cover property (key_wr);
endmodule
`default_nettype wire

// ===== bench/ilc_src_model.sv
// Link source model: data clock, frame marker and key bytes
`timescale 1ns/100ps
`default_nettype none
module ilc_src_model (
    input wire logic clk_sys_i,
    input wire logic run_i,
    input wire logic [7:0] err_i,
    input wire logic [63:0] key_i,
    output logic dclk_o,
    output logic frame_o,
    output logic [7:0] data_o
);
    int idx;
    logic first;
    // One byte per half period, set up two cycles before each edge
    initial begin
        dclk_o = 1'b0;
        frame_o = 1'b0;
        data_o = 8'h00;
        idx = 0;
        first = 1'b1;
        forever begin
            @(posedge clk_sys_i);
            #2;
            if (run_i || dclk_o) begin
                // word zero with frame, then one per edge
                data_o = key_i[idx*8 +: 8] ^ ((idx == 0) ? err_i : 8'h00);
                // frame held over the rising edge only
                frame_o = first && !dclk_o;
                repeat (2) @(posedge clk_sys_i);
                #2 dclk_o = ~dclk_o;
                // endless repeat, marker on the first pass only
                if (dclk_o) first = 1'b0;
                idx = (idx + 1) % 8;
            end else begin
                // Stopped: clock still, data inverts every cycle, so the last byte returns every other cycle
                data_o = ~data_o;
                frame_o = 1'b0;
                idx = 0;
                first = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/ilc_link_check_tb.sv
// Self-checking bench for the link checker and clock monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module ilc_link_check_tb;
    import ilc_pkg::*;
    typedef struct {logic we; logic [4:0] idx; logic [7:0] wd, ex;} ilc_row_t;
    logic clk_sys_i, srst_i, dclk, frame, conv, conv_on, strobe, run;
    logic sclk, sen_n, sdi, sdo, sdo_oe_n, alarm, active, ptr_rst, seen, txen;
    logic [7:0] ldata, err, v;
    logic [15:0] smp;
    logic [2:0] ptr;
    int mismatches = 0;
    int comparisons = 0;
    ilc_row_t rows [6] = '{'{1, 5'h0B, 8'h5A, 8'h5A}, '{0, 5'h09, 0, 8'h7A},
        '{1, 5'h05, 8'hFF, 0}, '{1, REG_MON_STAT, 8'hFF, 0},
        '{0, REG_MON_CTRL, 0, 0}, '{1, REG_KEY_LAST, 8'hC3, 8'hC3}};
    ilc_src_model ilc_src_model_i (.clk_sys_i(clk_sys_i), .run_i(run),
        .err_i(err), .key_i(64'hC3000000_005A007A), .dclk_o(dclk),
        .frame_o(frame), .data_o(ldata));
    ilc_link_check ilc_link_check_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .input_data_clock_i(dclk), .frame_marker_i(frame),
        .link_data_i(ldata), .conversion_clock_i(conv),
        .output_strobe_sync_i(strobe), .output_enable_pin_i(txen),
        .sample_i(16'h1234), .serial_clk_i(sclk),
        .serial_enable_n_i(sen_n), .serial_data_i(sdi),
        .serial_data_o(sdo), .serial_data_oe_n_o(sdo_oe_n),
        .alarm_output_pin_o(alarm), .analog_active_o(active),
        .sample_o(smp), .read_ptr_o(ptr), .read_ptr_reset_o(ptr_rst));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    // Serial frame, MSB first; half period kept above four clocks
    task automatic xfer(input logic [7:0] cmd, wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        sen_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = sh[i];
            tick(5);
            if (i < 8) rd[i] = sdo;
            sclk = 1'b1;
            tick(5);
            sclk = 1'b0;
        end
        tick(5);
        sen_n = 1'b1;
        tick(5);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        xfer({3'b000, a}, d, dummy);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        xfer({3'b100, a}, 8'h00, d);
    endtask
    // Sticky look at the read pointer reset pulse over n cycles
    task automatic watch_rst(input int n, output logic hit);
        hit = 1'b0;
        repeat (n) begin
            tick(1);
            hit = hit | ptr_rst;
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // System clock, 25 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Conversion clock at a quarter of the system rate
    initial begin
        conv = 1'b0;
        forever begin
            tick(2);
            if (conv_on) conv = ~conv;
        end
    end
    // Watchdog, well beyond the expected run of about 8600 cycles
    initial begin
        #1000000;
        mismatches++;
        end_of_test;
    end
    // Main sequence
    initial begin
        {srst_i, conv_on, strobe, run, sclk, sdi, txen} = 7'b1000001;
        sen_n = 1'b1;
        err = 8'h00;
        tick(10);
        srst_i = 1'b0;
        tick(1);
        `CHK(ptr, 3'h4)
        `CHK({sdo_oe_n, alarm}, 2'b10)
        conv_on = 1'b1;
        $display("test reset done");
        foreach (rows[r]) begin
            if (rows[r].we) wr(rows[r].idx, rows[r].wd);
            rd(rows[r].idx, v);
            `CHK(v, rows[r].ex)
        end
        $display("test registers done");
        // enable pin level reaches the output outside test mode
        txen = 1'b0;
        tick(2);
        `CHK(active, 1'b0)
        txen = 1'b1;
        tick(2);
        `CHK(active, 1'b1)
        err = 8'h01;
        wr(REG_TEST_CTRL, 8'h01);
        run = 1'b1;
        // Long run so setup glitches settle first
        tick(2400);
        `CHK(active, 1'b0)
        rd(REG_LANE_ERR, v);
        `CHK(v, 8'h01)
        rd(REG_ALARM_FLAGS, v);
        `CHK(v[PAT_ERR_BIT], 1'b1)
        wr(REG_LANE_ERR, 8'h00);
        rd(REG_LANE_ERR, v);
        `CHK(v, 8'h01)
        err = 8'h00;
        tick(100);
        wr(REG_LANE_ERR, 8'h00);
        wr(REG_ALARM_FLAGS, 8'h00);
        tick(100);
        rd(REG_LANE_ERR, v);
        `CHK(v, 8'h00)
        rd(REG_ALARM_FLAGS, v);
        `CHK(v[PAT_ERR_BIT], 1'b0)
        wr(REG_TEST_CTRL, 8'h00);
        $display("test pattern done");
        wr(REG_MON_CTRL, 8'h03);
        tick(40);
        rd(REG_MON_STAT, v);
        `CHK(v, 8'h00)
        `CHK(smp, 16'h1234)
        run = 1'b0;
        tick(40);
        rd(REG_MON_STAT, v);
        `CHK(v, 8'hC0)
        `CHK(smp, MIDSCALE)
        `CHK(alarm, 1'b1)
        wr(REG_MON_CTRL, 8'h1B);
        `CHK(alarm, 1'b0)
        // clock back first; single sync frame resets read pointer
        run = 1'b1;
        watch_rst(20, seen);
        `CHK(seen, 1'b1)
        // loss latch re-armed by zero then one, stays clear
        wr(REG_MON_CTRL, 8'h19);
        rd(REG_MON_STAT, v);
        `CHK(v, 8'h40)
        wr(REG_MON_CTRL, 8'h1B);
        tick(40);
        rd(REG_MON_STAT, v);
        `CHK(v, 8'h40)
        // mute latch re-armed last, output data back
        wr(REG_MON_CTRL, 8'h1A);
        wr(REG_MON_CTRL, 8'h03);
        rd(REG_MON_STAT, v);
        `CHK(v, 8'h00)
        `CHK(smp, 16'h1234)
        `CHK(alarm, 1'b0)
        $display("test monitor done");
        // dual sync, strobe, then alarm flags register reads zero
        wr(REG_SYNC_SEL, 8'h01);
        strobe = 1'b1;
        watch_rst(20, seen);
        strobe = 1'b0;
        `CHK(seen, 1'b1)
        rd(REG_ALARM_FLAGS, v);
        `CHK(v, 8'h00)
        $display("test strobe sync done");
        // Reset again in mid-run while the link still toggles
        srst_i = 1'b1;
        tick(2);
        `CHK(ptr, READ_PTR_RESET)
        srst_i = 1'b0;
        tick(1);
        `CHK({sdo_oe_n, alarm}, 2'b10)
        rd(5'h0B, v);
        `CHK(v, 8'h00)
        $display("test second reset done");
        end_of_test;
    end
endmodule
`default_nettype wire
